//--- bench/pfsws_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module pfsws_flash_model #(
  parameter int ADDR_W = 13,
  parameter int WORD_W = 14
) (
  input  wire logic              pclk,
  input  wire logic [ADDR_W-1:0] flash_addr,
  input  wire logic              flash_read_en,
  output logic      [WORD_W-1:0] flash_read_data,
  input  wire logic              flash_erase,
  input  wire logic              flash_write_en,
  input  wire logic [WORD_W-1:0] flash_write_data,
  output int                     write_count,
  output int                     order_errors
);
  // ************************************************
  // behavioural program array
  // ************************************************
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [WORD_W-1:0] held;
  logic [ADDR_W-1:0] erased_base;
  bit                erased;
  bit                rd_hold;
  // data only valid while a read is in flight, else inverted last word
  always @* begin
    if (flash_read_en || rd_hold) flash_read_data = mem[flash_addr];
    else flash_read_data = ~held;
  end
  always @(posedge pclk) begin
    rd_hold <= flash_read_en;
    if (flash_read_en || rd_hold) held <= mem[flash_addr];
    if (flash_erase) begin
      for (int i = 0; i < 4; i++) mem[{flash_addr[ADDR_W-1:2], 2'(i)}] <= '1;
      erased <= 1'b1;
      erased_base <= flash_addr;
    end
    if (flash_write_en) begin
      if (!erased || flash_addr[ADDR_W-1:2] != erased_base[ADDR_W-1:2])
        order_errors <= order_errors + 1;
      mem[flash_addr] <= flash_write_data;
      write_count <= write_count + 1;
      if (flash_addr[1:0] == 2'h3) erased <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- bench/pfsws_sequencer_props.sv
`timescale 1ns/10ps
`default_nettype none
module pfsws_sequencer_props
  import pfsws_pkg::*;
#(
  parameter int ADDR_W       = 13,
  parameter int WORD_W       = 14,
  parameter int ERASE_CYCLES = PFSWS_ERASE_CYCLES
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [1:0]        protect_region_bits,
  input wire logic              powerup_timer_busy,
  input wire logic              core_reset_event,
  input wire logic              core_squash,
  input wire logic              core_halt,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic              flash_read_en,
  input wire logic [WORD_W-1:0] flash_read_data,
  input wire logic              flash_erase,
  input wire logic              flash_write_en,
  input wire logic [WORD_W-1:0] flash_write_data
);
  // ************************************************
  // timing relations of the sequencer
  // ************************************************
  logic        trig_wr;
  logic        unlock_rd;
  logic [31:0] halt_cnt_reg;
  assign trig_wr = psel && penable && pwrite && paddr == PFSWS_OFF_CTRL
                   && pwdata[PFSWS_BIT_PROG] && pwdata[PFSWS_BIT_SPACE];
  assign unlock_rd = psel && penable && !pwrite && paddr == PFSWS_OFF_UNLOCK;
  // halted cycles before the first word, erase cycle included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_cnt_reg <= 32'h0;
    end else if (flash_erase) begin
      halt_cnt_reg <= 32'h1;
    end else if (core_halt && !flash_write_en) begin
      halt_cnt_reg <= halt_cnt_reg + 32'h1;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence squash_pair_s;
    core_squash ##1 core_squash ##1 !core_squash;
  endsequence
  sequence word_burst_s;
    flash_write_en && flash_addr[1:0] == 2'h0 ##1
    flash_write_en && flash_addr[1:0] == 2'h1 ##1
    flash_write_en && flash_addr[1:0] == 2'h2 ##1
    flash_write_en && flash_addr[1:0] == 2'h3 ##1 !flash_write_en;
  endsequence
  read_squash_a: assert property (flash_read_en |-> squash_pair_s)
    else $error("read did not squash exactly two cycles");
  erase_aligned_a: assert property (flash_erase |->
    flash_addr[1:0] == 2'h0)
    else $error("erase not on a block boundary");
  write_burst_a: assert property ($rose(flash_write_en) |->
    word_burst_s)
    else $error("block write not four ascending words");
  erase_cause_a: assert property (flash_erase |->
    $past(trig_wr, 3) && !$past(powerup_timer_busy, 3))
    else $error("erase without trigger three cycles earlier");
  erase_wait_a: assert property ($rose(flash_write_en) |->
    (halt_cnt_reg == ERASE_CYCLES || halt_cnt_reg == ERASE_CYCLES + 1))
    else $error("words written before erase time elapsed");
  halt_cover_a: assert property (flash_erase || flash_write_en |->
    core_halt)
    else $error("flash busy without core halt");
  halt_start_a: assert property ($rose(core_halt) |-> flash_erase)
    else $error("core halted without an erase");
  halt_release_a: assert property ($fell(flash_write_en) |->
    !core_halt)
    else $error("core still halted after last word");
  unlock_zero_a: assert property (unlock_rd |-> prdata == 32'h0)
    else $error("unlock port read not zero");
endmodule
bind pfsws_sequencer pfsws_sequencer_props #(.ADDR_W(ADDR_W), .WORD_W(WORD_W),
  .ERASE_CYCLES(ERASE_CYCLES)) pfsws_sequencer_props_inst (.*);
`default_nettype wire

//--- bench/pfsws_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pfsws_sequencer_tb;
  import pfsws_pkg::*;
  // ************************************************
  // bench for the flash self-write sequencer
  // ************************************************
  localparam int ERASE = 20;
  localparam logic [12:0] BASE = 13'h040;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, e;
  logic [1:0]  prot;
  logic        busy, rst_ev, squash, halt, rd_en, erase, wr_en;
  logic [12:0] faddr;
  logic [13:0] rdata, wdata;
  logic [13:0] words [4];
  logic [31:0] expq [$];
  int          num_errors, checks, cycles, seed, wcount, oerr;
  pfsws_sequencer #(.ERASE_CYCLES(ERASE)) pfsws_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .protect_region_bits(prot),
    .powerup_timer_busy(busy), .core_reset_event(rst_ev),
    .core_squash(squash), .core_halt(halt), .flash_addr(faddr),
    .flash_read_en(rd_en), .flash_read_data(rdata), .flash_erase(erase),
    .flash_write_en(wr_en), .flash_write_data(wdata));
  pfsws_flash_model pfsws_flash_model_inst (
    .pclk(pclk), .flash_addr(faddr), .flash_read_en(rd_en),
    .flash_read_data(rdata), .flash_erase(erase), .flash_write_en(wr_en),
    .flash_write_data(wdata), .write_count(wcount), .order_errors(oerr));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one idle cycle between transfers keeps psel edges clean
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    expq.push_back(exp);
    apb(a, 1'b0, 32'h0);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && expq.size() > 0) begin
      e = expq.pop_front();
      check("read data", prdata, e);
    end
  end
  task automatic prog(input logic [12:0] a, input logic [13:0] d,
                      input logic [7:0] k2);
    apb(PFSWS_OFF_ADDR_LO, 1'b1, {24'h0, a[7:0]});
    apb(PFSWS_OFF_ADDR_HI, 1'b1, {27'h0, a[12:8]});
    apb(PFSWS_OFF_DATA_LO, 1'b1, {24'h0, d[7:0]});
    apb(PFSWS_OFF_DATA_HI, 1'b1, {26'h0, d[13:8]});
    apb(PFSWS_OFF_UNLOCK, 1'b1, {24'h0, PFSWS_KEY_FIRST});
    apb(PFSWS_OFF_UNLOCK, 1'b1, {24'h0, k2});
    apb(PFSWS_OFF_CTRL, 1'b1, 32'h86);
  endtask
  // modes: 0 good, 1 skip word, 2 bad key, 3 timer, 4 protect,
  // 5 enable clear, 6 reset during erase
  task automatic block(input int mode);
    int   wc;
    logic ok;
    wc = wcount;
    ok = (mode == 0 || mode == 6);
    apb(PFSWS_OFF_STATUS, 1'b1, 32'h1);
    for (int i = 0; i < 4; i++) begin
      words[i] = 14'($random(seed));
      if (mode == 5) apb(PFSWS_OFF_CTRL, 1'b1, 32'h80);
      if (mode != 1 || i != 1)
        prog(BASE + 13'(i), words[i], mode == 2 ? 8'hAB : PFSWS_KEY_SECND);
      if (ok) begin
        @(posedge pclk) check("squash", {31'h0, squash}, 32'h1);
        @(posedge pclk) check("squash", {31'h0, squash}, 32'h1);
        @(posedge pclk) check("halt", {31'h0, halt}, 32'(i == 3));
      end else repeat (3) @(posedge pclk);
      if (mode == 6 && i == 3) begin
        rst_ev <= 1'b1;
        @(posedge pclk) rst_ev <= 1'b0;
      end
      while (halt === 1'b1) @(posedge pclk);
      if (ok && !(mode == 6 && i == 3)) begin
        check("squash", {31'h0, squash}, 32'h0);
        rd_chk(PFSWS_OFF_CTRL, 32'h84);
        rd_chk(PFSWS_OFF_STATUS, 32'h1);
        apb(PFSWS_OFF_STATUS, 1'b1, 32'h1);
      end
    end
    if (mode == 0) begin
      for (int i = 0; i < 4; i++)
        check("flash word", {18'h0, pfsws_flash_model_inst.mem[BASE + i]},
              {18'h0, words[i]});
      check("order", 32'(oerr), 32'h0);
    end else if (mode != 6)
      check("writes", 32'(wcount), 32'(wc));
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, rst_ev, paddr, pwdata} = '0;
    {num_errors, checks, cycles} = '0;
    prot = 2'b11;
    busy = 1'b1;
    seed = 97;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(PFSWS_OFF_CTRL, 32'h0);
    apb(PFSWS_OFF_CTRL, 1'b1, 32'h86);
    rd_chk(PFSWS_OFF_CTRL, 32'h84);
    apb(PFSWS_OFF_UNLOCK, 1'b1, 32'h55);
    rd_chk(PFSWS_OFF_UNLOCK, 32'h0);
    apb(8'h40, 1'b1, 32'h1);
    check("pslverr", {31'h0, serr}, 32'h1);
    busy <= 1'b0;
    block(0);
    apb(PFSWS_OFF_ADDR_LO, 1'b1, 32'h41);
    apb(PFSWS_OFF_ADDR_HI, 1'b1, 32'h0);
    apb(PFSWS_OFF_CTRL, 1'b1, 32'h85);
    repeat (2) @(posedge pclk) check("squash", {31'h0, squash}, 32'h1);
    rd_chk(PFSWS_OFF_DATA_LO, {24'h0, words[1][7:0]});
    rd_chk(PFSWS_OFF_DATA_HI, {26'h0, words[1][13:8]});
    apb(PFSWS_OFF_ADDR_LO, 1'b1, 32'h42);
    rd_chk(PFSWS_OFF_DATA_LO, {24'h0, words[1][7:0]});
    for (int m = 1; m < 7; m++) begin
      prot <= (m == 4) ? 2'b10 : 2'b11;
      busy <= (m == 3);
      block(m);
    end
    rd_chk(PFSWS_OFF_CTRL, 32'h8C);
    @(posedge pclk);
    conclude();
  end
endmodule
`default_nettype wire

//--- logic/pfsws_pkg.sv
package pfsws_pkg;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [7:0] PFSWS_OFF_ADDR_LO = 8'h00;
  localparam logic [7:0] PFSWS_OFF_ADDR_HI = 8'h04;
  localparam logic [7:0] PFSWS_OFF_DATA_LO = 8'h08;
  localparam logic [7:0] PFSWS_OFF_DATA_HI = 8'h0C;
  localparam logic [7:0] PFSWS_OFF_CTRL    = 8'h10;
  localparam logic [7:0] PFSWS_OFF_UNLOCK  = 8'h14;
  localparam logic [7:0] PFSWS_OFF_STATUS  = 8'h18;

  // ***************************************************************
  // control and status register fields
  // ***************************************************************
  localparam int PFSWS_BIT_FETCH  = 0;
  localparam int PFSWS_BIT_PROG   = 1;
  localparam int PFSWS_BIT_ENABLE = 2;
  localparam int PFSWS_BIT_ABORT  = 3;
  localparam int PFSWS_BIT_SPACE  = 7;
  localparam int PFSWS_BIT_DONE   = 0;

  // ***************************************************************
  // reset values, unlock keys, timing
  // ***************************************************************
  localparam logic [7:0] PFSWS_RST_BYTE  = 8'h00;
  localparam logic [7:0] PFSWS_KEY_FIRST = 8'h55;
  localparam logic [7:0] PFSWS_KEY_SECND = 8'hAA;
  localparam logic [1:0] PFSWS_LAST_IDX  = 2'h3;
  localparam int PFSWS_READ_CYCLES  = 2;
  localparam int PFSWS_SETUP_CYCLES = 2;
  localparam int PFSWS_CLK_MHZ      = 50;
  localparam int PFSWS_ERASE_US     = 4000;
  localparam int PFSWS_ERASE_CYCLES = PFSWS_ERASE_US * PFSWS_CLK_MHZ;

  // ***************************************************************
  // protected regions, upper word address per protect code
  // ***************************************************************
  localparam logic [12:0] PFSWS_PROT_TOP_00 = 13'h0FFF;
  localparam logic [12:0] PFSWS_PROT_TOP_01 = 13'h07FF;
  localparam logic [12:0] PFSWS_PROT_TOP_10 = 13'h00FF;

  typedef enum logic [4:0] {
    PFSWS_ST_IDLE  = 5'b00001,
    PFSWS_ST_READ  = 5'b00010,
    PFSWS_ST_SETUP = 5'b00100,
    PFSWS_ST_ERASE = 5'b01000,
    PFSWS_ST_PROG  = 5'b10000
  } pfsws_state_t;

  typedef enum logic [2:0] {
    PFSWS_UL_IDLE  = 3'b001,
    PFSWS_UL_FIRST = 3'b010,
    PFSWS_UL_READY = 3'b100
  } pfsws_unlock_t;

endpackage

//--- logic/pfsws_sequencer.sv
// What this block does
// - read takes two cycles, squashing two instructions
// - read data lands next cycle, held until replaced
// - writes into protected segments never take effect
// - writes only as aligned four-word blocks
// - each block commit erases then programs
// - last word triggers erase and block write
// - two setup cycles after trigger, instructions ignored
// - first three words load without stalling
// - core halts for erase time, clocks keep running
// - execution resumes at third instruction after trigger
// - program sequence to unfit location is ignored
// - program enable cleared at power-up
// - no write starts while power-up timer runs
// - write needs enable plus completed unlock sequence
// - completion clears trigger and sets done flag
// - trigger needs enable; clearing enable later harmless
// - reset during write sets abort flag
// - unlock port stores nothing and reads zero
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

module pfsws_sequencer
  import pfsws_pkg::*;
#(
  parameter int ADDR_W       = 13,
  parameter int WORD_W       = 14,
  parameter int ERASE_CYCLES = PFSWS_ERASE_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [1:0]        protect_region_bits,
  input  wire logic              powerup_timer_busy,
  input  wire logic              core_reset_event,
  output logic                   core_squash,
  output logic                   core_halt,
  output logic      [ADDR_W-1:0] flash_addr,
  output logic                   flash_read_en,
  input  wire logic [WORD_W-1:0] flash_read_data,
  output logic                   flash_erase,
  output logic                   flash_write_en,
  output logic      [WORD_W-1:0] flash_write_data
);

  localparam int HI_W = WORD_W - 8;
  localparam int AH_W = ADDR_W - 8;
  localparam int CNT_W = $clog2(ERASE_CYCLES + 1);
  localparam logic [CNT_W-1:0] ERASE_LAST =
    CNT_W'(ERASE_CYCLES - 1);

  // ***************************************************************
  // state
  // ***************************************************************
  logic [7:0]        addr_low_reg;
  logic [AH_W-1:0]   addr_high_reg;
  logic [7:0]        data_low_reg;
  logic [HI_W-1:0]   data_high_reg;
  logic              space_select_reg;
  logic              program_enable_reg;
  logic              program_abort_reg;
  logic              program_trigger_reg;
  logic              fetch_trigger_reg;
  logic              completion_reg;
  pfsws_state_t      state_reg;
  pfsws_unlock_t     unlock_reg;
  logic [CNT_W-1:0]  count_reg;
  logic [WORD_W-1:0] buf_reg [4];
  logic [3:0]        loaded_reg;
  logic [AH_W+5:0]   block_reg;
  logic [1:0]        prog_idx_reg;

  logic              wr_acc;
  logic              rd_acc;
  logic [ADDR_W-1:0] word_addr;
  logic              ctrl_wr;
  logic              fetch_go;
  logic              prog_go;
  logic              commit_ok;
  logic              seq_done;

  function automatic logic is_protected(input logic [1:0]        code,
                                        input logic [ADDR_W-1:0] a);
    logic [12:0] top;
    top = 13'h0000;
    case (code)
      2'b00:   top = PFSWS_PROT_TOP_00;
      2'b01:   top = PFSWS_PROT_TOP_01;
      2'b10:   top = PFSWS_PROT_TOP_10;
      default: top = 13'h0000;
    endcase
    return (code != 2'b11) && (a <= ADDR_W'(top));
  endfunction

  // ***************************************************************
  // bus decode
  // ***************************************************************
  assign pready    = 1'b1;
  assign wr_acc    = psel && penable && pwrite;
  assign rd_acc    = psel && penable && !pwrite;
  assign word_addr = {addr_high_reg, addr_low_reg};
  assign ctrl_wr   = wr_acc && (paddr == PFSWS_OFF_CTRL);

  always_comb begin
    pslverr = 1'b0;
    case (paddr)
      PFSWS_OFF_ADDR_LO, PFSWS_OFF_ADDR_HI, PFSWS_OFF_DATA_LO,
      PFSWS_OFF_DATA_HI, PFSWS_OFF_CTRL, PFSWS_OFF_UNLOCK,
      PFSWS_OFF_STATUS: pslverr = 1'b0;
      default:          pslverr = psel && penable;
    endcase
  end

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      PFSWS_OFF_ADDR_LO: prdata[7:0] = addr_low_reg;
      PFSWS_OFF_ADDR_HI: prdata[AH_W-1:0] = addr_high_reg;
      PFSWS_OFF_DATA_LO: prdata[7:0] = data_low_reg;
      PFSWS_OFF_DATA_HI: prdata[HI_W-1:0] = data_high_reg;
      PFSWS_OFF_CTRL: begin
        prdata[PFSWS_BIT_SPACE]  = space_select_reg;
        prdata[PFSWS_BIT_ABORT]  = program_abort_reg;
        prdata[PFSWS_BIT_ENABLE] = program_enable_reg;
        prdata[PFSWS_BIT_PROG]   = program_trigger_reg;
        prdata[PFSWS_BIT_FETCH]  = fetch_trigger_reg;
      end
      PFSWS_OFF_STATUS: prdata[PFSWS_BIT_DONE] = completion_reg;
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ***************************************************************
  // start conditions
  // ***************************************************************
  // trigger bits are set-only and only from idle, so a second
  // request during a busy sequence is simply dropped
  assign fetch_go = ctrl_wr && pwdata[PFSWS_BIT_FETCH] &&
                    pwdata[PFSWS_BIT_SPACE] &&
                    (state_reg == PFSWS_ST_IDLE) &&
                    !program_trigger_reg;
  assign prog_go  = ctrl_wr && pwdata[PFSWS_BIT_PROG] &&
                    pwdata[PFSWS_BIT_SPACE] &&
                    program_enable_reg &&
                    (unlock_reg == PFSWS_UL_READY) &&
                    !powerup_timer_busy &&
                    (state_reg == PFSWS_ST_IDLE) &&
                    !fetch_trigger_reg;

  // commit only a full, same-block, unprotected buffer
  assign commit_ok = (prog_idx_reg == PFSWS_LAST_IDX) &&
                     (&loaded_reg[2:0]) &&
                     (block_reg == word_addr[ADDR_W-1:2]) &&
                     !is_protected(protect_region_bits,
                                   word_addr);
  assign seq_done  = (state_reg == PFSWS_ST_PROG) &&
                     (prog_idx_reg == PFSWS_LAST_IDX);

  // ***************************************************************
  // address and data registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_low_reg  <= PFSWS_RST_BYTE;
      addr_high_reg <= '0;
    end else if (wr_acc && !core_halt) begin
      if (paddr == PFSWS_OFF_ADDR_LO) begin
        addr_low_reg <= pwdata[7:0];
      end
      if (paddr == PFSWS_OFF_ADDR_HI) begin
        addr_high_reg <= pwdata[AH_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_low_reg  <= PFSWS_RST_BYTE;
      data_high_reg <= '0;
    end else if (state_reg == PFSWS_ST_READ &&
                 count_reg == CNT_W'(PFSWS_READ_CYCLES - 1)) begin
      data_low_reg  <= flash_read_data[7:0];
      data_high_reg <= flash_read_data[WORD_W-1:8];
    end else if (wr_acc) begin
      if (paddr == PFSWS_OFF_DATA_LO) begin
        data_low_reg <= pwdata[7:0];
      end
      if (paddr == PFSWS_OFF_DATA_HI) begin
        data_high_reg <= pwdata[HI_W-1:0];
      end
    end
  end

  // ***************************************************************
  // control bits
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      space_select_reg   <= 1'b0;
      program_enable_reg <= 1'b0;
    end else if (ctrl_wr) begin
      // select frozen while a write runs; enable is not
      if (!program_trigger_reg) begin
        space_select_reg <= pwdata[PFSWS_BIT_SPACE];
      end
      program_enable_reg <= pwdata[PFSWS_BIT_ENABLE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_abort_reg <= 1'b0;
    end else if (core_reset_event && program_trigger_reg) begin
      program_abort_reg <= 1'b1;
    end else if (ctrl_wr) begin
      program_abort_reg <= pwdata[PFSWS_BIT_ABORT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_trigger_reg <= 1'b0;
    end else if (core_reset_event) begin
      program_trigger_reg <= 1'b0;
    end else if (prog_go) begin
      program_trigger_reg <= 1'b1;
    end else if (seq_done || (state_reg == PFSWS_ST_SETUP &&
                 count_reg == CNT_W'(PFSWS_SETUP_CYCLES - 1) &&
                 !commit_ok)) begin
      program_trigger_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_trigger_reg <= 1'b0;
    end else if (fetch_go && !core_reset_event) begin
      fetch_trigger_reg <= 1'b1;
    end else if (core_reset_event || (state_reg == PFSWS_ST_READ &&
                 count_reg == CNT_W'(PFSWS_READ_CYCLES - 1))) begin
      fetch_trigger_reg <= 1'b0;
    end
  end

  // set beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      completion_reg <= 1'b0;
    end else if (program_trigger_reg && !core_reset_event &&
                 (seq_done || (state_reg == PFSWS_ST_SETUP &&
                  count_reg == CNT_W'(PFSWS_SETUP_CYCLES - 1) &&
                  !commit_ok))) begin
      completion_reg <= 1'b1;
    end else if (wr_acc && paddr == PFSWS_OFF_STATUS &&
                 pwdata[PFSWS_BIT_DONE]) begin
      completion_reg <= 1'b0;
    end
  end

  // ***************************************************************
  // unlock detector
  // ***************************************************************
  // any other bus write in between drops the detector to idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_reg <= PFSWS_UL_IDLE;
    end else if (wr_acc) begin
      case (unlock_reg)
        PFSWS_UL_IDLE: begin
          if (paddr == PFSWS_OFF_UNLOCK &&
              pwdata[7:0] == PFSWS_KEY_FIRST) begin
            unlock_reg <= PFSWS_UL_FIRST;
          end
        end
        PFSWS_UL_FIRST: begin
          if (paddr == PFSWS_OFF_UNLOCK &&
              pwdata[7:0] == PFSWS_KEY_SECND) begin
            unlock_reg <= PFSWS_UL_READY;
          end else begin
            unlock_reg <= PFSWS_UL_IDLE;
          end
        end
        default: unlock_reg <= PFSWS_UL_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // sequencer
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= PFSWS_ST_IDLE;
      count_reg    <= '0;
      prog_idx_reg <= 2'h0;
    end else if (core_reset_event) begin
      state_reg <= PFSWS_ST_IDLE;
      count_reg <= '0;
    end else begin
      case (state_reg)
        PFSWS_ST_IDLE: begin
          count_reg <= '0;
          if (fetch_go) begin
            state_reg <= PFSWS_ST_READ;
          end else if (prog_go) begin
            state_reg    <= PFSWS_ST_SETUP;
            prog_idx_reg <= word_addr[1:0];
          end
        end
        PFSWS_ST_READ: begin
          count_reg <= count_reg + 1'b1;
          if (count_reg == CNT_W'(PFSWS_READ_CYCLES - 1)) begin
            state_reg <= PFSWS_ST_IDLE;
          end
        end
        PFSWS_ST_SETUP: begin
          count_reg <= count_reg + 1'b1;
          if (count_reg == CNT_W'(PFSWS_SETUP_CYCLES - 1)) begin
            count_reg <= '0;
            // only the last word stalls; others end here
            state_reg <= commit_ok ? PFSWS_ST_ERASE
                                   : PFSWS_ST_IDLE;
          end
        end
        PFSWS_ST_ERASE: begin
          count_reg <= count_reg + 1'b1;
          if (count_reg == ERASE_LAST) begin
            state_reg    <= PFSWS_ST_PROG;
            prog_idx_reg <= 2'h0;
          end
        end
        PFSWS_ST_PROG: begin
          prog_idx_reg <= prog_idx_reg + 1'b1;
          if (prog_idx_reg == PFSWS_LAST_IDX) begin
            state_reg <= PFSWS_ST_IDLE;
          end
        end
        default: state_reg <= PFSWS_ST_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // block buffer
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_reg <= 4'h0;
      block_reg  <= '0;
      for (int i = 0; i < 4; i++) begin
        buf_reg[i] <= '0;
      end
    end else if (state_reg == PFSWS_ST_SETUP && count_reg == '0) begin
      buf_reg[prog_idx_reg] <= {data_high_reg, data_low_reg};
      if (prog_idx_reg == 2'h0) begin
        loaded_reg <= 4'h1;
        block_reg  <= word_addr[ADDR_W-1:2];
      end else if (block_reg == word_addr[ADDR_W-1:2] &&
                   loaded_reg[prog_idx_reg - 1'b1]) begin
        loaded_reg[prog_idx_reg] <= 1'b1;
      end else begin
        loaded_reg <= 4'h0;
      end
    end else if (seq_done) begin
      loaded_reg <= 4'h0;
    end
  end

  // ***************************************************************
  // core and flash outputs
  // ***************************************************************
  // squash covers the two instructions after either trigger
  assign core_squash = (state_reg == PFSWS_ST_READ) ||
                       (state_reg == PFSWS_ST_SETUP);
  // clocks keep running; only instruction issue stops
  assign core_halt   = (state_reg == PFSWS_ST_ERASE) ||
                       (state_reg == PFSWS_ST_PROG) || flash_write_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_addr       <= '0;
      flash_read_en    <= 1'b0;
      flash_erase      <= 1'b0;
      flash_write_en   <= 1'b0;
      flash_write_data <= '0;
    end else begin
      flash_read_en  <= fetch_go;
      flash_erase    <= (state_reg == PFSWS_ST_SETUP) &&
                        (count_reg == CNT_W'(PFSWS_SETUP_CYCLES - 1)) &&
                        commit_ok && !core_reset_event;
      flash_write_en <= (state_reg == PFSWS_ST_PROG) &&
                        !core_reset_event;
      if (fetch_go) begin
        flash_addr <= word_addr;
      end else if (state_reg == PFSWS_ST_SETUP) begin
        flash_addr <= {word_addr[ADDR_W-1:2], 2'h0};
      end else if (state_reg == PFSWS_ST_PROG) begin
        flash_addr       <= {block_reg, prog_idx_reg};
        flash_write_data <= buf_reg[prog_idx_reg];
      end
    end
  end

endmodule

`default_nettype wire
